// ===== gsc_pkg.sv
`default_nettype none
package gsc_pkg;
   localparam int unsigned ADDR_W = 32;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned PIN_N = 14;
   localparam logic [31:0] PORT0_SET_OFS = 32'hffff_0d24;
   localparam logic [31:0] PORT0_CLR_OFS = 32'hffff_0d28;
   localparam logic [31:0] PORT1_SET_OFS = 32'hffff_0d34;
   localparam logic [31:0] PORT1_CLR_OFS = 32'hffff_0d38;
   localparam logic [31:0] PORT2_SET_OFS = 32'hffff_0d44;
   localparam logic [31:0] PORT2_CLR_OFS = 32'hffff_0d48;
   // field positions in the written word
   localparam int unsigned P0_LSB = 16;
   localparam int unsigned P0_MSB = 20;
   localparam int unsigned P1_LSB = 16;
   localparam int unsigned P1_MSB = 17;
   localparam int unsigned P2_LO_LSB = 16;
   localparam int unsigned P2_LO_MSB = 17;
   localparam int unsigned P2_HI_LSB = 21;
   localparam int unsigned P2_HI_MSB = 22;
   localparam logic [13:0] LATCH_RST = 14'h0000;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== gsc_pin_map.sv
`timescale 1ns/1ps
`default_nettype none
// maps one written word into a 14-pin mask for the addressed port
module gsc_pin_map (
   input wire logic [1:0] port_sel,
   input wire logic [31:0] wdata,
   output logic [13:0] mask
);
   always_comb begin
      mask = 14'h0000;
      case (port_sel)
         2'b00: begin
            mask[4:0] = wdata[gsc_pkg::P0_MSB:gsc_pkg::P0_LSB];
         end
         2'b01: begin
            mask[6:5] = wdata[gsc_pkg::P1_MSB:gsc_pkg::P1_LSB];
         end
         2'b10: begin
            mask[8:7] = wdata[gsc_pkg::P2_LO_MSB:gsc_pkg::P2_LO_LSB];
            mask[13:12] = wdata[gsc_pkg::P2_HI_MSB:gsc_pkg::P2_HI_LSB];
         end
         default: begin
            mask = 14'h0000;
         end
      endcase
   end
endmodule
`default_nettype wire

// ===== gsc_top.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_top (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [31:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_stb,
   input wire logic rd_stb,
   output logic [31:0] rdata,
   input wire logic data_wr,
   input wire logic [13:0] data_wval,
   output logic [13:0] pin_out
);
   logic [13:0] latch_q;
   logic [13:0] mask;
   logic [1:0] port_sel;
   logic is_set;
   logic hit;
   logic [31:0] rdata_q;

   // decode: port index, set/clear, hit
   always_comb begin
      hit = wr_stb;
      port_sel = 2'b11;
      is_set = 1'b0;
      case (addr)
         gsc_pkg::PORT0_SET_OFS: begin port_sel = 2'b00; is_set = 1'b1; end
         gsc_pkg::PORT0_CLR_OFS: begin port_sel = 2'b00; end
         gsc_pkg::PORT1_SET_OFS: begin port_sel = 2'b01; is_set = 1'b1; end
         gsc_pkg::PORT1_CLR_OFS: begin port_sel = 2'b01; end
         gsc_pkg::PORT2_SET_OFS: begin port_sel = 2'b10; is_set = 1'b1; end
         gsc_pkg::PORT2_CLR_OFS: begin port_sel = 2'b10; end
         default: begin hit = 1'b0; end
      endcase
   end

   gsc_pin_map u_map (
      .port_sel(port_sel),
      .wdata(wdata),
      .mask(mask)
   );

   // shared output latch; data-register write loads only when no set/clear write hits that cycle, set/clear only touch one-bits
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         latch_q <= gsc_pkg::LATCH_RST;
      end else if (hit && is_set) begin
         latch_q <= latch_q | mask;
      end else if (hit) begin
         latch_q <= latch_q & ~mask;
      end else if (data_wr) begin
         latch_q <= data_wval;
      end
   end

   // write-only words read as zero
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= gsc_pkg::READ_ZERO;
      end else begin
         rdata_q <= gsc_pkg::READ_ZERO;
      end
   end

   assign rdata = rdata_q;
   assign pin_out = latch_q;

   a_set_drives: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && addr == gsc_pkg::PORT1_SET_OFS) |=> (pin_out[6:5] ==
      ($past(pin_out[6:5]) | $past(wdata[17:16]))))
      else $error("port1 set not applied");
   a_clr_drives: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && addr == gsc_pkg::PORT2_CLR_OFS) |=> (pin_out[13:12] ==
      ($past(pin_out[13:12]) & ~$past(wdata[22:21]))))
      else $error("port2 clear not applied");
   a_p0_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && addr == gsc_pkg::PORT0_CLR_OFS) |=> (pin_out[4:0] ==
      ($past(pin_out[4:0]) & ~$past(wdata[20:16]))))
      else $error("port0 clear not applied");
   a_other_kept: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && addr == gsc_pkg::PORT0_SET_OFS) |=> (pin_out[13:5] ==
      $past(pin_out[13:5])))
      else $error("other port disturbed");
   a_read_zero: assert property (@(posedge clk_sys) disable iff (!rst_n)
      rd_stb |=> rdata == 32'h0000_0000)
      else $error("read not zero");
   a_p2_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && addr == gsc_pkg::PORT2_SET_OFS) |=> (pin_out[8:7] ==
      ($past(pin_out[8:7]) | $past(wdata[17:16]))))
      else $error("port2 set not applied");
   a_p1_clr: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && addr == gsc_pkg::PORT1_CLR_OFS) |=> (pin_out[6:5] ==
      ($past(pin_out[6:5]) & ~$past(wdata[17:16]))))
      else $error("port1 clear not applied");
   a_p0_set: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (wr_stb && addr == gsc_pkg::PORT0_SET_OFS) |=> (pin_out[4:0] ==
      ($past(pin_out[4:0]) | $past(wdata[20:16]))))
      else $error("port0 set not applied");
endmodule
`default_nettype wire

// ===== gsc_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module gsc_pin_model (
   input wire logic clk_sys,
   input wire logic [13:0] pin_out,
   output logic [13:0] pin_q
);
   always_ff @(posedge clk_sys) pin_q <= pin_out;
endmodule
`default_nettype wire

// ===== gpio_set_clear_ports_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module gpio_set_clear_ports_tb_top;
   logic clk_sys = 1'b0, rst_n = 1'b0, wr_stb = 1'b0, rd_stb = 1'b0, data_wr = 1'b0, rdc, w;
   logic [31:0] addr = '0, wdata = '0, rdata;
   logic [13:0] data_wval = '0, pin_out, pin_q, exp_pins = '0, prev;
   int error_cnt = 0, check_count = 0, cyc = 0, k = 0;
   logic [31:0] adr_tab [7] = '{gsc_pkg::PORT0_SET_OFS, gsc_pkg::PORT0_CLR_OFS,
      gsc_pkg::PORT1_SET_OFS, gsc_pkg::PORT1_CLR_OFS, gsc_pkg::PORT2_SET_OFS,
      gsc_pkg::PORT2_CLR_OFS, 32'hffff_0d2c};
   gsc_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wdata(wdata),
      .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .data_wr(data_wr),
      .data_wval(data_wval), .pin_out(pin_out));
   gsc_pin_model i_pins (.clk_sys(clk_sys), .pin_out(pin_out), .pin_q(pin_q));
   initial forever #2.5 clk_sys = ~clk_sys;
   function automatic logic [13:0] step(logic [31:0] a, logic [31:0] d, logic [13:0] o);
      logic [13:0] m0, m1, m2;
      m0 = {9'h000, d[20:16]};
      m1 = {7'h00, d[17:16], 5'h00};
      m2 = {d[22:21], 3'h0, d[17:16], 7'h00};
      case (a)
         gsc_pkg::PORT0_SET_OFS: return o | m0;
         gsc_pkg::PORT0_CLR_OFS: return o & ~m0;
         gsc_pkg::PORT1_SET_OFS: return o | m1;
         gsc_pkg::PORT1_CLR_OFS: return o & ~m1;
         gsc_pkg::PORT2_SET_OFS: return o | m2;
         gsc_pkg::PORT2_CLR_OFS: return o & ~m2;
         default: return data_wr ? data_wval : o;
      endcase
   endfunction
   // bits that software may write as 1 at each address; all else is reserved
   function automatic logic [31:0] legal(logic [31:0] a);
      case (a)
         gsc_pkg::PORT0_SET_OFS, gsc_pkg::PORT0_CLR_OFS: return 32'h001f_0000;
         gsc_pkg::PORT1_SET_OFS, gsc_pkg::PORT1_CLR_OFS: return 32'h0003_0000;
         gsc_pkg::PORT2_SET_OFS, gsc_pkg::PORT2_CLR_OFS: return 32'h0063_0000;
         default: return 32'h0000_0000;
      endcase
   endfunction
   task chk(string n, logic [31:0] s, logic [31:0] e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task final_report;
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 5000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      void'($urandom(32'h926a_491e));
      repeat (16) @(posedge clk_sys);
      rst_n <= 1'b1;
      for (int i = 0; i < 2000; i++) begin
         @(posedge clk_sys);
         prev = exp_pins;
         exp_pins = !rst_n ? 14'h0000 : step(wr_stb ? addr : 32'h0000_0000, wdata, exp_pins);
         rdc = rd_stb;
         rst_n <= (i != 300);
         // async reset clears the latch at once
         if (i == 300) exp_pins = 14'h0000;
         w = 1'($urandom_range(1));
         wr_stb <= w;
         rd_stb <= !w && $urandom_range(1);
         k = $urandom_range(6);
         addr <= adr_tab[k];
         wdata <= (i % 8 == 0) ? legal(adr_tab[k]) : ($urandom & legal(adr_tab[k]));
         data_wr <= ($urandom_range(7) == 0);
         data_wval <= 14'($urandom);
         @(negedge clk_sys);
         chk("pin_out", {18'h0_0000, pin_out}, {18'h0_0000, exp_pins});
         chk("pin_q", {18'h0_0000, pin_q}, {18'h0_0000, prev});
         if (rdc) chk("rdata", rdata, gsc_pkg::READ_ZERO);
      end
      $display("test random_mix done");
      final_report();
   end
endmodule
`default_nettype wire
